// >>> design/backplane_tx_framer_regs.vh
// Register map, field positions, reset values and frame constants of the
// backplane transmit framer.
// Assumes a Wishbone byte address of four bits, one 32-bit word per register.
`ifndef BACKPLANE_TX_FRAMER_REGS_VH
`define BACKPLANE_TX_FRAMER_REGS_VH

// ************************************************************
// Register byte addresses
// ************************************************************
`define BTF_CTRL_ADDR      4'h0
`define BTF_SERDES_ADDR    4'h4
`define BTF_STATUS_ADDR    4'h8

// ************************************************************
// Control register fields
// ************************************************************
`define BTF_PAR_INH        0
`define BTF_PAR_ERR        1
`define BTF_FRM_ERR        2
`define BTF_AIS            3
`define BTF_SCR_EN         4
`define BTF_PWR_DN         5
`define BTF_SOFT_OFF       6
`define BTF_BUF_CLR        7
`define BTF_QRATE          8
`define BTF_RDI_EN         9
`define BTF_TRANSP         10
`define BTF_CTRL_W         11
`define BTF_CTRL_RST       11'h010

// ************************************************************
// Serializer register fields
// ************************************************************
`define BTF_EQ_LSB         0
`define BTF_AMP            3
`define BTF_GPC_LSB        8
`define BTF_SERDES_RST     16'h0000

// ************************************************************
// Status register fields
// ************************************************************
`define BTF_GPS_LSB        0
`define BTF_LEVEL_LSB      8
`define BTF_OVFL           11

// ************************************************************
// Frame geometry and overhead values
// ************************************************************
`define BTF_SLOT_LAST      6'd47
`define BTF_COL_LAST_STD   7'd89
`define BTF_ROW_LAST_STD   4'd8
`define BTF_COL_LAST_SHORT 7'd5
`define BTF_ROW_LAST_SHORT 4'd1
`define BTF_A1_LAST3       6'd45
`define BTF_A2_FIRST3      6'd3
`define BTF_A1_VAL         8'hf6
`define BTF_A1_ERR_VAL     8'hf7
`define BTF_A2_VAL         8'h28
`define BTF_PAR_ERR_MASK   8'h80
`define BTF_SCR_SEED       7'h7f
`define BTF_KEEP_CHANNEL   36
`define BTF_FIFO_DEPTH     4

`endif

// >>> design/backplane_tx_framer.v
// Backplane transmit framer for one channel: framing, section parity,
// scrambling, alarm fill, remote defect and quarter-rate expansion.
// Assumes one core byte per cycle with valid, a frame-sync pulse on the first
// byte of each frame and a serializer that pulls bytes with a ready.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ns
`include "backplane_tx_framer_regs.vh"

module backplane_tx_framer #(
  parameter CHANNEL_INDEX = 0
) (
  input  wire        mclk_in,
  input  wire        rst_b_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [3:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  input  wire [7:0]  core_data_in,
  input  wire        core_valid_in,
  input  wire        core_sync_in,
  input  wire        short_frame_in,
  input  wire        rx_alarm_in,
  output reg  [7:0]  tx_data_out,
  output reg         tx_valid_out,
  input  wire        tx_ready_in,
  output reg         tx_power_down_out,
  output reg         tx_enable_out,
  output reg  [2:0]  drive_equalization_select_out,
  output reg         output_amplitude_select_out,
  output reg  [7:0]  serializer_gp_control_out,
  input  wire [7:0]  serializer_gp_status_in
);

  // ************************************************************
  // Functions
  // ************************************************************
  // Eight keystream bits MSB first, then the advanced state
  function [14:0] scr_step;
    input [6:0] s;
    reg   [6:0] st;
    reg   [7:0] ks;
    integer     i;
    begin
      st = s;
      ks = 8'h00;
      for (i = 7; i >= 0; i = i - 1) begin
        ks[i] = st[6];
        st = {st[5:0], st[6] ^ st[5]};
      end
      scr_step = {st, ks};
    end
  endfunction

  // Byte idx of the fourfold bit expansion of b
  function [7:0] expand;
    input [7:0] b;
    input [1:0] idx;
    reg         hi;
    reg         lo;
    begin
      hi = b[3'd7 - {idx, 1'b0}];
      lo = b[3'd6 - {idx, 1'b0}];
      expand = {{4{hi}}, {4{lo}}};
    end
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  reg  [`BTF_CTRL_W-1:0] ctrl;
  reg  [15:0]            serdes;
  reg                    overflow;
  wire                   wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;

  // ************************************************************
  // Control field decode
  // ************************************************************
  wire par_inh   = ctrl[`BTF_PAR_INH];
  wire par_err   = ctrl[`BTF_PAR_ERR];
  wire frm_err   = ctrl[`BTF_FRM_ERR];
  wire transp    = ctrl[`BTF_TRANSP];
  wire ais_on    = ctrl[`BTF_AIS] & ~transp;
  wire scr_en    = ctrl[`BTF_SCR_EN];
  wire soft_off  = ctrl[`BTF_SOFT_OFF];
  wire buf_clr   = ctrl[`BTF_BUF_CLR];
  wire qrate     = ctrl[`BTF_QRATE];
  wire rdi_en    = ctrl[`BTF_RDI_EN];

  reg  [2:0] level;
  reg  [7:0] gps;

  // ************************************************************
  // Register bus, one wait state per access
  // ************************************************************
  // Ack registered so a held request is taken only once
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl       <= `BTF_CTRL_RST;
      serdes     <= `BTF_SERDES_RST;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      gps        <= 8'h00;
    end else begin
      gps        <= serializer_gp_status_in;
      wb_ack_out <= wb_req;
      wb_dat_out <= 32'h0000_0000;
      if (wb_req && wb_we_in) begin
        if (wb_adr_in == `BTF_CTRL_ADDR) begin
          if (wb_sel_in[0])
            ctrl[7:0] <= wb_dat_in[7:0];
          if (wb_sel_in[1])
            ctrl[`BTF_CTRL_W-1:8] <= wb_dat_in[`BTF_CTRL_W-1:8];
        end
        if (wb_adr_in == `BTF_SERDES_ADDR) begin
          if (wb_sel_in[0])
            serdes[7:0] <= wb_dat_in[7:0];
          if (wb_sel_in[1])
            serdes[15:8] <= wb_dat_in[15:8];
        end
      end
      if (wb_req && !wb_we_in) begin
        case (wb_adr_in)
          `BTF_CTRL_ADDR: begin
            wb_dat_out <= {21'h000000, ctrl};
          end
          `BTF_SERDES_ADDR: begin
            wb_dat_out <= {16'h0000, serdes};
          end
          `BTF_STATUS_ADDR: begin
            wb_dat_out <= {20'h00000, overflow, level, gps};
          end
          default: begin
            wb_dat_out <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Serializer controls
  // ************************************************************
  // All registered so the macro never sees decode glitches
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_power_down_out             <= 1'b0;
      tx_enable_out                 <= 1'b0;
      drive_equalization_select_out <= 3'h0;
      output_amplitude_select_out   <= 1'b0;
      serializer_gp_control_out     <= 8'h00;
    end else begin
      // Channel 36 keeps its port powered by design
      tx_power_down_out <= ctrl[`BTF_PWR_DN] & (CHANNEL_INDEX != `BTF_KEEP_CHANNEL);
      tx_enable_out     <= ~soft_off;
      drive_equalization_select_out <= serdes[`BTF_EQ_LSB+2:`BTF_EQ_LSB];
      output_amplitude_select_out   <= serdes[`BTF_AMP];
      serializer_gp_control_out     <= serdes[`BTF_GPC_LSB+7:`BTF_GPC_LSB];
    end
  end

  // ************************************************************
  // Frame position counters
  // ************************************************************
  reg  [5:0] slot;
  reg  [6:0] col;
  reg  [3:0] row;
  // Sync forces position zero in its own cycle
  wire [5:0] p_slot = core_sync_in ? 6'd0 : slot;
  wire [6:0] p_col  = core_sync_in ? 7'd0 : col;
  wire [3:0] p_row  = core_sync_in ? 4'd0 : row;
  wire [6:0] col_last = short_frame_in ? `BTF_COL_LAST_SHORT : `BTF_COL_LAST_STD;
  wire [3:0] row_last = short_frame_in ? `BTF_ROW_LAST_SHORT : `BTF_ROW_LAST_STD;
  wire       running  = core_valid_in & ~soft_off;

  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      slot <= 6'd0;
      col  <= 7'd0;
      row  <= 4'd0;
    end else if (soft_off) begin
      slot <= 6'd0;
      col  <= 7'd0;
      row  <= 4'd0;
    end else if (core_valid_in) begin
      slot <= p_slot + 6'd1;
      col  <= p_col;
      row  <= p_row;
      if (p_slot == `BTF_SLOT_LAST) begin
        slot <= 6'd0;
        col  <= p_col + 7'd1;
        if (p_col >= col_last) begin
          col <= 7'd0;
          row <= (p_row >= row_last) ? 4'd0 : p_row + 4'd1;
        end
      end
    end
  end

  // ************************************************************
  // Overhead insertion and scrambling
  // ************************************************************
  reg  [6:0]  scr;
  reg  [7:0]  bip_acc;
  reg  [7:0]  bip_prev;
  reg  [7:0]  hold;
  reg  [7:0]  b;
  reg  [7:0]  s_byte;
  reg  [7:0]  out_byte;
  wire [14:0] scr_nx   = scr_step(scr);
  wire        row0     = p_row == 4'd0;
  wire        is_a1    = row0 && p_col == 7'd0;
  wire        is_a2    = row0 && p_col == 7'd1;
  wire        is_jz    = row0 && p_col == 7'd2;
  wire        is_b1    = p_row == 4'd1 && p_col == 7'd0;
  wire        is_k2    = p_row == 4'd4 && p_col == 7'd2 && p_slot == 6'd0;
  wire        unscr    = row0 && p_col < 7'd3;
  wire        first    = ~qrate | (p_slot[1:0] == 2'd0);
  wire        in_line  = p_row >= 4'd3 || p_col >= 7'd3;
  wire        frame_start = is_a1 && p_slot == 6'd0;

  always @* begin
    b = core_data_in;
    if (ais_on && !(is_a1 || is_a2 || is_b1)) begin
      if (is_jz)
        b = {2'b00, p_slot};
      else if (in_line)
        b = 8'hff;
    end
    if (is_a1 && (ais_on || p_slot >= `BTF_A1_LAST3))
      b = frm_err ? `BTF_A1_ERR_VAL : `BTF_A1_VAL;
    if (is_a2 && (ais_on || p_slot < `BTF_A2_FIRST3))
      b = `BTF_A2_VAL;
    if (is_b1 && p_slot == 6'd0 && !par_inh)
      b = bip_prev ^ (par_err ? `BTF_PAR_ERR_MASK : 8'h00);
    // Applied last so neither alarm fill nor other overhead can mask it
    if (is_k2 && rdi_en && rx_alarm_in)
      b[2:0] = 3'b000;
    s_byte = (scr_en && !unscr) ? b ^ scr_nx[7:0] : b;
  end

  // ************************************************************
  // Output select and quarter-rate expansion
  // ************************************************************
  // Group followers replay the held leader byte
  always @* begin
    out_byte = s_byte;
    if (transp)
      out_byte = core_data_in;
    else if (qrate)
      out_byte = expand(first ? s_byte : hold, p_slot[1:0]);
  end

  // ************************************************************
  // Scrambler state and group hold
  // ************************************************************
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scr  <= `BTF_SCR_SEED;
      hold <= 8'h00;
    end else if (running && first) begin
      hold <= s_byte;
      // Reseeded across the unscrambled row-0 overhead, frame aligned
      scr  <= unscr ? `BTF_SCR_SEED : scr_nx[14:8];
    end
  end

  // ************************************************************
  // Section parity
  // ************************************************************
  // Leaders only, the rest are copies after expansion
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bip_acc  <= 8'h00;
      bip_prev <= 8'h00;
    end else if (running && first) begin
      if (frame_start) begin
        bip_prev <= bip_acc;
        bip_acc  <= s_byte;
      end else begin
        bip_acc <= bip_acc ^ s_byte;
      end
    end
  end

  // ************************************************************
  // Output FIFO
  // ************************************************************
  // Core stream cannot stall; a full FIFO drops the byte and flags it
  reg  [7:0] mem [0:`BTF_FIFO_DEPTH-1];
  reg  [1:0] wr_ptr;
  reg  [1:0] rd_ptr;
  wire       flush = soft_off | buf_clr;
  wire       rd_en = tx_ready_in && level != 3'd0 && !flush;
  wire       wr_ok = running && !buf_clr && (level != 3'd4 || rd_en);
  integer    k;

  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr   <= 2'd0;
      rd_ptr   <= 2'd0;
      level    <= 3'd0;
      overflow <= 1'b0;
      for (k = 0; k < `BTF_FIFO_DEPTH; k = k + 1)
        mem[k] <= 8'h00;
    end else if (flush) begin
      wr_ptr   <= 2'd0;
      rd_ptr   <= 2'd0;
      level    <= 3'd0;
      overflow <= 1'b0;
    end else begin
      if (rd_en)
        rd_ptr <= rd_ptr + 2'd1;
      if (wr_ok) begin
        mem[wr_ptr] <= out_byte;
        wr_ptr      <= wr_ptr + 2'd1;
      end
      if (running && !wr_ok)
        overflow <= 1'b1;
      // Level one bit wider than pointers, so full and empty differ
      level <= level + {2'b00, wr_ok} - {2'b00, rd_en};
    end
  end

  // ************************************************************
  // Serializer handoff register
  // ************************************************************
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_data_out  <= 8'h00;
      tx_valid_out <= 1'b0;
    end else if (flush) begin
      tx_data_out  <= 8'h00;
      tx_valid_out <= 1'b0;
    end else begin
      tx_valid_out <= rd_en;
      if (rd_en)
        tx_data_out <= mem[rd_ptr];
    end
  end

endmodule

// >>> verif/backplane_tx_framer_monitor.sv
// Port checker for the backplane transmit framer.
// Assumes it is bound to the framer and sees only its ports.
`timescale 1ns/1ns
`include "backplane_tx_framer_regs.vh"
module backplane_tx_framer_monitor #(
  parameter CHANNEL_INDEX = 0
) (
  input wire logic        mclk_in,
  input wire logic        rst_b_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [3:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic        wb_ack_out,
  input wire logic        tx_ready_in,
  input wire logic        tx_valid_out,
  input wire logic        tx_power_down_out,
  input wire logic        tx_enable_out,
  input wire logic [2:0]  drive_equalization_select_out,
  input wire logic        output_amplitude_select_out,
  input wire logic [7:0]  serializer_gp_control_out
);
  // ****************************************
  // Write decode, data kept past release
  // ****************************************
  reg  [31:0] wd;
  wire        req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire        wc  = req && wb_we_in && wb_adr_in == `BTF_CTRL_ADDR && wb_sel_in[0];
  wire        ws  = req && wb_we_in && wb_adr_in == `BTF_SERDES_ADDR;
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      wd <= 32'h0;
    else if (req)
      wd <= wb_dat_in;
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_ack; req |=> wb_ack_out ##1 !wb_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
  property p_valid; tx_valid_out |-> $past(tx_ready_in); endproperty
  a_valid: assert property (p_valid) else $error("byte sent without pull");
  property p_keep; tx_power_down_out |-> CHANNEL_INDEX != `BTF_KEEP_CHANNEL; endproperty
  a_keep: assert property (p_keep) else $error("kept channel powered down");
  property p_pwr; wc |-> ##[1:3] tx_power_down_out == (wd[5] && CHANNEL_INDEX != 36); endproperty
  a_pwr: assert property (p_pwr) else $error("power down mismatch");
  property p_soft; wc |-> ##[1:3] tx_enable_out == !wd[6]; endproperty
  a_soft: assert property (p_soft) else $error("soft off mismatch");
  property p_eq; ws && wb_sel_in[0] |-> ##[1:3] drive_equalization_select_out == wd[2:0]; endproperty
  a_eq: assert property (p_eq) else $error("equalization mismatch");
  property p_amp; ws && wb_sel_in[0] |-> ##[1:3] output_amplitude_select_out == wd[3]; endproperty
  a_amp: assert property (p_amp) else $error("amplitude mismatch");
  property p_gpc; ws && wb_sel_in[1] |-> ##[1:3] serializer_gp_control_out == wd[15:8]; endproperty
  a_gpc: assert property (p_gpc) else $error("gp control mismatch");
endmodule

bind backplane_tx_framer backplane_tx_framer_monitor #(.CHANNEL_INDEX(CHANNEL_INDEX)) mon_inst (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_ack_out(wb_ack_out), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
  .tx_power_down_out(tx_power_down_out), .tx_enable_out(tx_enable_out),
  .drive_equalization_select_out(drive_equalization_select_out),
  .output_amplitude_select_out(output_amplitude_select_out),
  .serializer_gp_control_out(serializer_gp_control_out));

// >>> verif/serializer_model.sv
// Serializer side of the link: pulls bytes and records them.
// Assumes the bench stalls it through stall_in.
`timescale 1ns/1ns
module serializer_model (
  input  wire       mclk_in,
  input  wire       rst_b_in,
  input  wire       stall_in,
  input  wire [7:0] tx_data_in,
  input  wire       tx_valid_in,
  output wire       tx_ready_out,
  output wire [7:0] gp_status_out
);
  logic [7:0] got[$];
  // Pulls one byte a cycle unless stalled
  assign tx_ready_out  = rst_b_in && !stall_in;
  assign gp_status_out = 8'h5a;
  always @(posedge mclk_in) begin
    if (tx_valid_in)
      got.push_back(tx_data_in);
  end
endmodule

// >>> verif/backplane_tx_framer_tb.sv
// Self-checking bench for the backplane transmit framer.
// Assumes short frames, save one standard frame run with the receiver alarm up.
`timescale 1ns/1ns
`include "backplane_tx_framer_regs.vh"
module backplane_tx_framer_tb;
  reg         mclk_in = 1'h0;
  reg         rst_b_in = 1'h0;
  reg         cyc = 1'h0, stb = 1'h0, we = 1'h0, stall = 1'h0, valid = 1'h0, sync = 1'h0;
  reg  [3:0]  adr = 4'h0;
  reg  [3:0]  sel = 4'h3;
  reg  [31:0] wdat = 32'h0;
  reg  [31:0] q;
  reg  [7:0]  dat = 8'h0;
  reg  [7:0]  x;
  reg         short_frm = 1'h1, rx_alarm = 1'h0;
  integer     j;
  wire [31:0] rdat;
  wire [7:0]  txd, gpc, gps;
  wire [2:0]  eq;
  wire        ack, txv, rdy, pd, en, amp;
  integer     num_errors = 0;
  integer     cmp_count = 0;
  integer     cycles = 0;
  always #20 mclk_in = ~mclk_in;
  backplane_tx_framer backplane_tx_framer_inst (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .core_data_in(dat), .core_valid_in(valid), .core_sync_in(sync), .short_frame_in(short_frm),
    .rx_alarm_in(rx_alarm), .tx_data_out(txd), .tx_valid_out(txv), .tx_ready_in(rdy),
    .tx_power_down_out(pd), .tx_enable_out(en), .drive_equalization_select_out(eq),
    .output_amplitude_select_out(amp), .serializer_gp_control_out(gpc),
    .serializer_gp_status_in(gps));
  serializer_model serializer_model_inst (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .stall_in(stall), .tx_data_in(txd),
    .tx_valid_in(txv), .tx_ready_out(rdy), .gp_status_out(gps));
  // ****************************************
  // Checks, verdict and hang guard
  // ****************************************
  task chk(input [31:0] seen, input [31:0] want, input string nm);
    cmp_count = cmp_count + 1;
    if (seen !== want) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task complete_run;
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  // ****************************************
  // Bus cycle, core stream and expectations
  // ****************************************
  task bus(input [3:0] a, input w, input [31:0] d, output [31:0] r);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge mclk_in);
    while (ack !== 1'h1)
      @(posedge mclk_in);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge mclk_in);
  endtask
  task push(input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      valid <= 1'h1;
      sync <= (i == 0);
      dat <= i[7:0];
      @(posedge mclk_in);
    end
    valid <= 1'h0;
    sync <= 1'h0;
  endtask
  // Modes: 0 plain, 1 framing error, 2 transparent, 3 alarm fill, 4 quarter rate
  function [7:0] expb(input integer m, input integer i);
    reg [7:0] f;
    f = (m == 1) ? `BTF_A1_ERR_VAL : `BTF_A1_VAL;
    case (m)
      2: expb = i[7:0];
      3: expb = i < 48 ? f : i < 96 ? `BTF_A2_VAL : i[7:0] - 8'h60;
      4: expb = {{4{f[7 - 2 * (i % 4)]}}, {4{f[6 - 2 * (i % 4)]}}};
      default: expb = (i >= 45 && i < 48) ? f : (i >= 48 && i < 51) ? `BTF_A2_VAL : i[7:0];
    endcase
  endfunction
  task stream(input [31:0] c, input integer n);
    bus(`BTF_CTRL_ADDR, 1'h1, c, q);
    serializer_model_inst.got.delete();
    push(n);
    repeat (8) @(posedge mclk_in);
    chk(serializer_model_inst.got.size(), n, "byte count");
  endtask
  task run(input integer m, input integer n, input [31:0] c);
    integer i;
    stream(c, n);
    for (i = 0; i < n; i = i + 1)
      chk(serializer_model_inst.got[i], expb(m, i), "stream byte");
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_b_in <= 1'h1;
    bus(`BTF_CTRL_ADDR, 1'h0, 32'h0, q);
    chk(q, 32'h10, "ctrl reset");
    bus(`BTF_SERDES_ADDR, 1'h1, 32'hab0d, q);
    bus(`BTF_SERDES_ADDR, 1'h0, 32'h0, q);
    chk(q, 32'hab0d, "serdes");
    chk({gpc, 4'h0, amp, eq}, 32'hab0d, "serdes pins");
    bus(`BTF_STATUS_ADDR, 1'h0, 32'h0, q);
    chk(q, 32'h5a, "status");
    bus(4'hc, 1'h0, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    bus(`BTF_CTRL_ADDR, 1'h1, 32'h060, q);
    repeat (3) @(posedge mclk_in);
    chk(pd, 32'h1, "power down");
    chk(en, 32'h0, "enable");
    run(0, 96, 32'h000);
    run(1, 96, 32'h004);
    run(2, 96, 32'h418);
    run(3, 144, 32'h018);
    bus(`BTF_CTRL_ADDR, 1'h1, 32'h080, q);
    run(4, 48, 32'h108);
    bus(`BTF_CTRL_ADDR, 1'h1, 32'h080, q);
    stream(32'h002, 865);
    x = 8'h80;
    for (j = 0; j < 576; j = j + 1)
      x = x ^ serializer_model_inst.got[j];
    chk(serializer_model_inst.got[864], x, "section parity");
    stream(32'h001, 289);
    chk(serializer_model_inst.got[288], 32'h20, "parity inhibit");
    short_frm <= 1'h0;
    rx_alarm <= 1'h1;
    stream(32'h208, 17377);
    chk(serializer_model_inst.got[17375], 32'hff, "line fill");
    chk(serializer_model_inst.got[17376], 32'hf8, "remote defect");
    short_frm <= 1'h1;
    rx_alarm <= 1'h0;
    bus(`BTF_CTRL_ADDR, 1'h1, 32'h400, q);
    serializer_model_inst.got.delete();
    stall <= 1'h1;
    push(5);
    repeat (4) @(posedge mclk_in);
    bus(`BTF_STATUS_ADDR, 1'h0, 32'h0, q);
    chk(q, 32'hc5a, "full status");
    bus(`BTF_CTRL_ADDR, 1'h1, 32'h480, q);
    bus(`BTF_CTRL_ADDR, 1'h1, 32'h400, q);
    bus(`BTF_STATUS_ADDR, 1'h0, 32'h0, q);
    chk(q, 32'h5a, "cleared status");
    stall <= 1'h0;
    repeat (8) @(posedge mclk_in);
    chk(serializer_model_inst.got.size(), 0, "flushed");
    complete_run;
  end
endmodule
